// ===== src/scl_cfg.svh
// Constants for the serial command link protocol engine
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH

`define SCL_STX           8'h02
`define SCL_ETX           8'h03
`define SCL_EOT           8'h04
`define SCL_ACK           8'h06
`define SCL_LF            8'h0a
`define SCL_CR            8'h0d
`define SCL_NAK           8'h15

`define SCL_CLK_HZ        10000000
`define SCL_TIMEOUT_S     15
`define SCL_TIMEOUT_CYC   (`SCL_TIMEOUT_S * `SCL_CLK_HZ)

`endif

// ===== src/scl_pkg.sv
// Types for the serial command link protocol engine
`default_nettype none
package scl_pkg;
    typedef enum logic [3:0] {
        SCL_IDLE,
        SCL_RX_BODY,
        SCL_RX_ETX,
        SCL_WAIT_PARSE,
        SCL_SEND_VERDICT,
        SCL_WAIT_EOT,
        SCL_WAIT_DATA,
        SCL_TX_STX,
        SCL_TX_DATA,
        SCL_TX_CR,
        SCL_TX_LF,
        SCL_TX_ETX,
        SCL_WAIT_ACK,
        SCL_TX_EOT
    } scl_state_t;
endpackage
`default_nettype wire

// ===== src/scl_skid.sv
// Two-entry buffer with valid/ready on both sides
`default_nettype none
module scl_skid #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem_reg [2];
    logic [WIDTH-1:0] mem_next [2];
    logic             wp_reg, wp_next, rp_reg, rp_next;
    logic [1:0]       cnt_reg, cnt_next;
    logic             push, pop;
    logic             ov_reg, ov_next;
    logic [WIDTH-1:0] od_reg, od_next;

    assign push      = in_valid && (cnt_reg != 2'h2);
    assign pop       = out_ready && (cnt_reg != 2'h0);
    assign in_ready  = (cnt_reg != 2'h2);
    // Head word and valid kept in flops so the outputs carry no mux
    assign out_valid = ov_reg;
    assign out_data  = od_reg;

    always_comb begin
        mem_next = mem_reg;
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        cnt_next = cnt_reg;
        if (push) begin
            mem_next[wp_reg] = in_data;
            wp_next          = ~wp_reg;
        end
        if (pop) begin
            rp_next = ~rp_reg;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 2'h1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 2'h1;
        end
        ov_next = (cnt_next != 2'h0);
        od_next = mem_next[rp_next];
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wp_reg     <= 1'b0;
            rp_reg     <= 1'b0;
            cnt_reg    <= 2'h0;
            ov_reg     <= 1'b0;
            od_reg     <= '0;
        end else begin
            mem_reg <= mem_next;
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
            ov_reg  <= ov_next;
            od_reg  <= od_next;
        end
    end
endmodule // scl_skid
`default_nettype wire

// ===== src/scl_link.sv
// Device-side serial command link protocol engine
`include "scl_cfg.svh"
`default_nettype none
module scl_link #(
    parameter int TIMEOUT_CYC = `SCL_TIMEOUT_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       rx_valid,
    output logic            rx_ready,
    input  wire logic [7:0] rx_data,
    output logic            tx_valid,
    input  wire logic       tx_ready,
    output logic [7:0]      tx_data,
    output logic            cmd_valid,
    output logic [7:0]      cmd_data,
    output logic            cmd_last,
    output logic            cmd_abort,
    input  wire logic       verdict_valid,
    input  wire logic       verdict_ok,
    input  wire logic       verdict_query,
    output logic            verdict_ready,
    input  wire logic       resp_valid,
    input  wire logic [7:0] resp_data,
    input  wire logic       resp_last,
    input  wire logic       resp_none,
    output logic            resp_ready
);
    // ****************************************
    // State
    // ****************************************
    scl_pkg::scl_state_t state_reg, state_next;
    logic [31:0] tmr_reg, tmr_next;
    logic        tmr_on_reg, tmr_on_next;
    logic        ok_reg, ok_next, qry_reg, qry_next;
    logic        pend_reg, pend_next;
    logic [7:0]  pd_reg, pd_next;
    logic        full_next;
    logic        cv_reg, cv_next, cl_reg, cl_next, ca_reg, ca_next;
    logic [7:0]  cd_reg, cd_next;
    logic        rr_reg, rr_next, vr_reg, vr_next, pr_reg, pr_next;
    logic        bv, br;
    logic [7:0]  bd;
    logic        expired;
    logic        rx_take;

    // Buffer holds outgoing bytes so a receiver stall loses none
    scl_skid #(.WIDTH(8)) u_txbuf (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .in_valid  (bv),
        .in_ready  (br),
        .in_data   (bd),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    assign expired  = tmr_on_reg && (tmr_reg == 32'(TIMEOUT_CYC - 1));
    assign rx_take  = rx_valid && rx_ready;
    assign rx_ready = rr_reg;
    assign cmd_valid     = cv_reg;
    assign cmd_data      = cd_reg;
    assign cmd_last      = cl_reg;
    assign cmd_abort     = ca_reg;
    assign verdict_ready = vr_reg;
    assign resp_ready    = pr_reg;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        state_next    = state_reg;
        tmr_next      = tmr_on_reg ? tmr_reg + 32'h1 : 32'h0;
        tmr_on_next   = tmr_on_reg;
        ok_next       = ok_reg;
        qry_next      = qry_reg;
        pend_next     = pend_reg;
        pd_next       = pd_reg;
        cv_next       = 1'b0;
        cl_next       = 1'b0;
        ca_next       = 1'b0;
        cd_next       = cd_reg;
        bv            = 1'b0;
        bd            = 8'h00;
        case (state_reg)
            scl_pkg::SCL_IDLE: begin
                if (rx_take && rx_data == `SCL_STX) begin
                    state_next  = scl_pkg::SCL_RX_BODY;
                    tmr_on_next = 1'b1;
                    tmr_next    = 32'h0;
                end
            end
            scl_pkg::SCL_RX_BODY, scl_pkg::SCL_RX_ETX: begin
                if (expired) begin
                    state_next  = scl_pkg::SCL_IDLE;
                    tmr_on_next = 1'b0;
                    ca_next     = 1'b1;
                    pend_next   = 1'b0;
                end else if (pend_reg) begin
                    // Byte held back behind an embedded LF; receive is paused meanwhile
                    cv_next   = 1'b1;
                    cd_next   = pd_reg;
                    pend_next = 1'b0;
                end else if (rx_take) begin
                    if (rx_data == `SCL_ETX) begin
                        tmr_on_next = 1'b0;
                        if (state_reg == scl_pkg::SCL_RX_ETX) begin
                            state_next = scl_pkg::SCL_WAIT_PARSE;
                            cv_next    = 1'b1;
                            cl_next    = 1'b1;
                            cd_next    = `SCL_LF;
                        end else begin
                            // Frame without LF before ETX is malformed: refuse it
                            state_next = scl_pkg::SCL_SEND_VERDICT;
                            ok_next    = 1'b0;
                            qry_next   = 1'b0;
                            ca_next    = 1'b1;
                        end
                    end else if (state_reg == scl_pkg::SCL_RX_ETX) begin
                        // Embedded LF was command data; a byte after it other than LF follows next cycle
                        cv_next = 1'b1;
                        cd_next = `SCL_LF;
                        if (rx_data != `SCL_LF) begin
                            state_next = scl_pkg::SCL_RX_BODY;
                            pend_next  = 1'b1;
                            pd_next    = rx_data;
                        end
                    end else if (rx_data == `SCL_LF) begin
                        state_next = scl_pkg::SCL_RX_ETX;
                    end else begin
                        cv_next = 1'b1;
                        cd_next = rx_data;
                    end
                end
            end
            scl_pkg::SCL_WAIT_PARSE: begin
                if (verdict_valid && vr_reg) begin
                    ok_next    = verdict_ok;
                    qry_next   = verdict_query;
                    state_next = scl_pkg::SCL_SEND_VERDICT;
                end
            end
            scl_pkg::SCL_SEND_VERDICT: begin
                bv = 1'b1;
                bd = ok_reg ? `SCL_ACK : `SCL_NAK;
                if (br) begin
                    state_next = (ok_reg && qry_reg) ? scl_pkg::SCL_WAIT_EOT
                                                     : scl_pkg::SCL_IDLE;
                end
            end
            scl_pkg::SCL_WAIT_EOT: begin
                if (rx_take && rx_data == `SCL_EOT) begin
                    state_next = scl_pkg::SCL_WAIT_DATA;
                end else if (rx_take && rx_data == `SCL_STX) begin
                    // Host dropped the query and opened a new frame
                    state_next  = scl_pkg::SCL_RX_BODY;
                    tmr_on_next = 1'b1;
                    tmr_next    = 32'h0;
                end
            end
            scl_pkg::SCL_WAIT_DATA: begin
                if (resp_valid && resp_none) begin
                    state_next = scl_pkg::SCL_TX_EOT;
                end else if (resp_valid) begin
                    state_next = scl_pkg::SCL_TX_STX;
                end
            end
            scl_pkg::SCL_TX_STX: begin
                bv = 1'b1;
                bd = `SCL_STX;
                if (br) begin
                    state_next = scl_pkg::SCL_TX_DATA;
                end
            end
            scl_pkg::SCL_TX_DATA: begin
                // Ready is raised only with buffer room, so a taken byte always fits
                bv = resp_valid && pr_reg;
                bd = resp_data;
                if (resp_valid && pr_reg && resp_last) begin
                    state_next = scl_pkg::SCL_TX_CR;
                end
            end
            scl_pkg::SCL_TX_CR: begin
                bv = 1'b1;
                bd = `SCL_CR;
                if (br) begin
                    state_next = scl_pkg::SCL_TX_LF;
                end
            end
            scl_pkg::SCL_TX_LF: begin
                bv = 1'b1;
                bd = `SCL_LF;
                if (br) begin
                    state_next = scl_pkg::SCL_TX_ETX;
                end
            end
            scl_pkg::SCL_TX_ETX: begin
                bv = 1'b1;
                bd = `SCL_ETX;
                if (br) begin
                    state_next  = scl_pkg::SCL_WAIT_ACK;
                    tmr_on_next = 1'b1;
                    tmr_next    = 32'h0;
                end
            end
            scl_pkg::SCL_WAIT_ACK: begin
                if (expired) begin
                    tmr_on_next = 1'b0;
                    state_next  = scl_pkg::SCL_TX_EOT;
                end else if (rx_take && rx_data == `SCL_ACK) begin
                    tmr_on_next = 1'b0;
                    state_next  = scl_pkg::SCL_WAIT_DATA;
                end
            end
            scl_pkg::SCL_TX_EOT: begin
                bv = 1'b1;
                bd = `SCL_EOT;
                if (br) begin
                    state_next = scl_pkg::SCL_IDLE;
                end
            end
            default: begin
                state_next  = scl_pkg::SCL_IDLE;
                tmr_on_next = 1'b0;
            end
        endcase
        if (!tmr_on_next) begin
            tmr_next = 32'h0;
        end
        // Handshake readies registered so outputs come from flops
        rr_next = ((state_next == scl_pkg::SCL_IDLE) || (state_next == scl_pkg::SCL_RX_BODY) ||
                   (state_next == scl_pkg::SCL_RX_ETX) || (state_next == scl_pkg::SCL_WAIT_EOT) ||
                   (state_next == scl_pkg::SCL_WAIT_ACK)) && !pend_next;
        vr_next = (state_next == scl_pkg::SCL_WAIT_PARSE) &&
                  !(state_reg == scl_pkg::SCL_WAIT_PARSE && verdict_valid && vr_reg);
        // Buffer full after this edge, worked out from its valid and ready
        full_next = (!br && !(tx_valid && tx_ready)) || (br && tx_valid && bv && !tx_ready);
        pr_next = ((state_next == scl_pkg::SCL_TX_DATA) && !full_next) ||
                  ((state_reg == scl_pkg::SCL_WAIT_DATA) && resp_valid && resp_none);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= scl_pkg::SCL_IDLE;
            tmr_reg      <= 32'h0;
            tmr_on_reg   <= 1'b0;
            ok_reg       <= 1'b0;
            qry_reg      <= 1'b0;
            pend_reg     <= 1'b0;
            pd_reg       <= 8'h00;
            cv_reg       <= 1'b0;
            cl_reg       <= 1'b0;
            ca_reg       <= 1'b0;
            cd_reg       <= 8'h00;
            rr_reg       <= 1'b0;
            vr_reg       <= 1'b0;
            pr_reg       <= 1'b0;
        end else begin
            state_reg    <= state_next;
            tmr_reg      <= tmr_next;
            tmr_on_reg   <= tmr_on_next;
            ok_reg       <= ok_next;
            qry_reg      <= qry_next;
            pend_reg     <= pend_next;
            pd_reg       <= pd_next;
            cv_reg       <= cv_next;
            cl_reg       <= cl_next;
            ca_reg       <= ca_next;
            cd_reg       <= cd_next;
            rr_reg       <= rr_next;
            vr_reg       <= vr_next;
            pr_reg       <= pr_next;
        end
    end
endmodule // scl_link
`default_nettype wire

// ===== tb/scl_link_props.sv
// Port-level checks of the serial command link engine
`default_nettype none
module scl_link_props #(
    parameter int TIMEOUT_CYC = 50
) (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic       cmd_last,
    input wire logic       cmd_abort,
    input wire logic       verdict_valid,
    input wire logic       verdict_ok,
    input wire logic       verdict_ready,
    input wire logic       resp_valid,
    input wire logic       resp_last,
    input wire logic       resp_none,
    input wire logic       resp_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Shadow timers, counted from the wire events
    // ************************************************************
    wire logic rx_t = rx_valid && rx_ready;
    wire logic tx_t = tx_valid && tx_ready;
    int        rsp_reg, rsp_next, rcv_reg, rcv_next;
    always_comb begin
        rsp_next = (rsp_reg != 0) ? rsp_reg + 1 : 0;
        rcv_next = (rcv_reg != 0) ? rcv_reg + 1 : 0;
        if (tx_t && tx_data == 8'h03) rsp_next = 1;
        if ((rx_t && rx_data == 8'h06) || (tx_t && tx_data == 8'h04)) rsp_next = 0;
        if (rx_t && rx_data == 8'h02) rcv_next = 1;
        if ((rx_t && rx_data == 8'h03) || cmd_abort) rcv_next = 0;
    end
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_reg <= 0;
            rcv_reg <= 0;
        end else begin
            rsp_reg <= rsp_next;
            rcv_reg <= rcv_next;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_ack_byte: assert property (verdict_valid && verdict_ready && verdict_ok
        |-> ##[1:4] tx_valid && tx_data == 8'h06) else $error("ack byte missing");
    a_nak_byte: assert property (verdict_valid && verdict_ready && !verdict_ok
        |-> ##[1:4] tx_valid && tx_data == 8'h15) else $error("refusal byte missing");
    a_tx_hold: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable(tx_data)) else $error("tx byte dropped while stalled");
    a_last_ready: assert property (cmd_last |-> ##[1:2] verdict_ready)
        else $error("verdict not requested");
    a_block_tail: assert property (resp_valid && resp_ready && resp_last
        |-> ##[1:20] tx_t && tx_data == 8'h0d) else $error("block tail missing");
    a_end_eot: assert property (resp_valid && resp_ready && resp_none
        |-> ##[1:6] tx_valid && tx_data == 8'h04) else $error("closing byte missing");
    a_rsp_limit: assert property (rsp_reg <= TIMEOUT_CYC + 16)
        else $error("response wait too long");
    a_rsp_early: assert property (tx_t && tx_data == 8'h04 && rsp_reg != 0
        |-> rsp_reg + 12 >= TIMEOUT_CYC) else $error("response timeout too early");
    a_rcv_limit: assert property (rcv_reg <= TIMEOUT_CYC + 4)
        else $error("receive wait too long");
    a_rcv_early: assert property (cmd_abort && rcv_reg != 0
        |-> rcv_reg + 2 >= TIMEOUT_CYC) else $error("receive timeout too early");
    c_ack: cover property (verdict_valid && verdict_ready && verdict_ok);
    c_abort: cover property (cmd_abort);
    c_none: cover property (resp_valid && resp_ready && resp_none);
endmodule // scl_link_props
bind scl_link scl_link_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_scl_link_props (
    .clk_sys, .sys_rst, .rx_valid, .rx_ready, .rx_data, .tx_valid, .tx_ready, .tx_data,
    .cmd_last, .cmd_abort, .verdict_valid, .verdict_ok, .verdict_ready,
    .resp_valid, .resp_last, .resp_none, .resp_ready
);
`default_nettype wire

// ===== tb/scl_host_model.sv
// Host side of the serial byte link
`default_nettype none
module scl_host_model (
    input  wire logic       clk_sys,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic [7:0]      rx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Byte traffic
    // ************************************************************
    int         seed = 42;
    logic [7:0] got[$];
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b0;
    end
    // Random stalls keep the two-entry buffer full at times
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        tx_ready <= ($random(seed) & 3) != 0;
    end
    task automatic send(input logic [7:0] b);
        @(posedge clk_sys);
        rx_valid <= 1'b1;
        rx_data  <= b;
        do @(posedge clk_sys); while (rx_ready !== 1'b1);
        rx_valid <= 1'b0;
        rx_data  <= ~b;
    endtask
endmodule // scl_host_model
`default_nettype wire

// ===== tb/scl_link_tb.sv
// Self-checking testbench of the serial command link engine
`default_nettype none
module scl_link_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef logic [7:0] scl_bytes_t[$];
    localparam int TO = 50;
    logic       clk_sys = 1'b0;
    logic       sys_rst;
    logic       rx_valid, rx_ready, tx_valid, tx_ready;
    logic [7:0] rx_data, tx_data, cmd_data;
    logic       cmd_valid, cmd_last, cmd_abort, verdict_ready, resp_ready;
    logic       verdict_valid, verdict_ok, verdict_query;
    logic       resp_valid, resp_last, resp_none;
    logic [7:0] resp_data;
    int         seed = 42, mismatches = 0, n_compared = 0, n_abort = 0;
    scl_bytes_t cmd_q;
    always #50 clk_sys = ~clk_sys;
    scl_link #(.TIMEOUT_CYC(TO)) u_scl_link (.clk_sys, .sys_rst, .rx_valid, .rx_ready,
        .rx_data, .tx_valid, .tx_ready, .tx_data, .cmd_valid, .cmd_data, .cmd_last,
        .cmd_abort, .verdict_valid, .verdict_ok, .verdict_query, .verdict_ready,
        .resp_valid, .resp_data, .resp_last, .resp_none, .resp_ready);
    scl_host_model u_scl_host_model (.clk_sys, .rx_valid, .rx_ready, .rx_data,
        .tx_valid, .tx_ready, .tx_data);
    // ************************************************************
    // Parser side and helpers
    // ************************************************************
    always @(posedge clk_sys) begin
        if (cmd_valid && !cmd_last) cmd_q.push_back(cmd_data);
        if (cmd_abort) n_abort++;
    end
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp_q(input scl_bytes_t got, input scl_bytes_t exp, input string what);
        bit ok;
        n_compared++;
        ok = got.size() == exp.size();
        foreach (exp[i]) if (i < got.size() && got[i] !== exp[i]) ok = 0;
        if (!ok) begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic cmp_n(input int got, input int exp, input string what);
        n_compared++;
        if (got != exp) begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    function automatic scl_bytes_t rand_body(input int n);
        scl_bytes_t q;
        repeat (n) q.push_back(8'h20 + 8'($random(seed) & 32'h3f));
        return q;
    endfunction
    function automatic scl_bytes_t block_frame(input scl_bytes_t d);
        return {8'h02, d, 8'h0d, 8'h0a, 8'h03};
    endfunction
    task automatic expect_tx(input scl_bytes_t exp);
        scl_bytes_t got;
        int         k;
        k = 0;
        while (u_scl_host_model.got.size() < exp.size() && k < 400) begin
            @(posedge clk_sys);
            k++;
        end
        got = u_scl_host_model.got;
        u_scl_host_model.got = {};
        cmp_q(got, exp, "device bytes");
    endtask
    task automatic give_resp(input scl_bytes_t q, input bit none);
        int n;
        n = none ? 1 : q.size();
        for (int i = 0; i < n; i++) begin
            resp_valid <= 1'b1;
            resp_none  <= none;
            resp_data  <= none ? 8'h00 : q[i];
            resp_last  <= !none && i == n - 1;
            do @(posedge clk_sys); while (resp_ready !== 1'b1);
        end
        resp_valid <= 1'b0;
    endtask
    // One exchange; drop leaves the first block unanswered
    task automatic command(input bit ok, input bit qry, input int nblk, input bit drop);
        scl_bytes_t body, blk;
        body = rand_body(1 + ($random(seed) & 3));
        // Corner case: LF inside the body and right before the frame's own LF
        if (nblk == 2) body = {8'h0a, body, 8'h0a};
        u_scl_host_model.send(8'h02);
        foreach (body[i]) u_scl_host_model.send(body[i]);
        u_scl_host_model.send(8'h0a);
        u_scl_host_model.send(8'h03);
        repeat (TO + 10) @(posedge clk_sys);
        verdict_valid <= 1'b1;
        verdict_ok    <= ok;
        verdict_query <= qry;
        do @(posedge clk_sys); while (verdict_ready !== 1'b1);
        verdict_valid <= 1'b0;
        cmp_q(cmd_q, body, "command body");
        cmd_q = {};
        expect_tx({ok ? 8'h06 : 8'h15});
        if (!(ok && qry)) return;
        u_scl_host_model.send(8'h04);
        repeat (nblk) begin
            blk = rand_body(1 + ($random(seed) & 3));
            give_resp(blk, 1'b0);
            expect_tx(block_frame(blk));
            if (drop) begin
                repeat (TO - 15) @(posedge clk_sys);
                cmp_n(u_scl_host_model.got.size(), 0, "early end");
                expect_tx({8'h04});
                return;
            end
            u_scl_host_model.send(8'h06);
            repeat (TO + 10) @(posedge clk_sys);
        end
        give_resp(blk, 1'b1);
        expect_tx({8'h04});
    endtask
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        scl_bytes_t junk;
        sys_rst       <= 1'b1;
        verdict_valid <= 1'b0;
        verdict_ok    <= 1'b0;
        verdict_query <= 1'b0;
        resp_valid    <= 1'b0;
        resp_last     <= 1'b0;
        resp_none     <= 1'b0;
        resp_data     <= 8'h00;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        junk = rand_body(3);
        junk.push_back(8'h03);
        foreach (junk[i]) u_scl_host_model.send(junk[i]);
        repeat (5) @(posedge clk_sys);
        cmp_n(cmd_q.size() + u_scl_host_model.got.size(), 0, "idle noise");
        for (int i = 0; i < 8; i++) command(i % 4 != 1, i % 2 == 0, i % 3, 1'b0);
        cmp_n(n_abort, 0, "abort after full frame");
        command(1'b1, 1'b1, 1, 1'b1);
        u_scl_host_model.send(8'h02);
        u_scl_host_model.send(8'h41);
        repeat (TO - 10) @(posedge clk_sys);
        cmp_n(n_abort, 0, "abort too early");
        repeat (20) @(posedge clk_sys);
        cmp_n(n_abort, 1, "abort missing");
        cmd_q = {};
        command(1'b1, 1'b0, 0, 1'b0);
        u_scl_host_model.send(8'h02);
        u_scl_host_model.send(8'h41);
        u_scl_host_model.send(8'h03);
        expect_tx({8'h15});
        cmp_n(n_abort, 2, "frame without LF kept");
        cmd_q = {};
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        end_sim;
    end
endmodule // scl_link_tb
`default_nettype wire
